// file: logic/sdg_gate.sv
// Input signal-detect gate with AXI4-Lite registers.
`timescale 1ns/10ps
module sdg_gate import sdg_pkg::*; #(
  parameter int HOLD_TICK = HOLD_STEP_CYC
) (
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [15:0] i_awaddr,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  output logic [1:0]       o_bresp,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  input  wire logic [15:0] i_araddr,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  input  wire sdg_smp_t    i_smp,
  output sdg_smp_t         o_smp,
  output logic             o_irq,
  output logic [1:0]       o_mic_clk,
  output logic [1:0]       o_mic_clk_oe,
  output logic [1:0]       o_mic_dat_oe,
  output logic [1:0]       o_mic_dat_pd,
  output logic [2:0]       o_anc_left_src,
  output logic [2:0]       o_anc_right_src
);
  logic [NCH-1:0] chan_detect_enable;
  logic [4:0]     detect_threshold_level;
  logic [3:0]     detect_hold_time;
  logic [1:0]     path_input_type_select;
  logic [1:0]     path_enable;
  logic [1:0]     pad_pulldown;
  logic [2:0]     rx_cancel_left_source;
  logic [2:0]     rx_cancel_right_source;
  logic           irq_stat;
  logic           irq_mask;
  logic [NCH-1:0] gate_open;
  logic [NCH-1:0] above;
  logic [7:0]     hold_cnt [NCH];
  logic           armed;
  logic           det_event;
  logic [31:0]    tick_cnt;
  logic           tick;
  logic [7:0]     mic_div;
  logic           mic_phase;
  sdg_wr_t        wr_state;
  logic [15:0]    aw_addr;
  logic [31:0]    w_data;
  logic [3:0]     w_strb;
  logic           aw_have;
  logic           w_have;

  // Maps a byte address to a channel number, or NCH when none.
  function automatic logic [3:0] chan_of(input logic [15:0] a);
    logic [13:0] ix;
    ix = a[15:2];
    if (ix == IDX_CH0) chan_of = 4'h0;
    else if (ix == IDX_CH1) chan_of = 4'h1;
    else if (ix == IDX_CH2) chan_of = 4'h2;
    else if (ix == IDX_CH3) chan_of = 4'h3;
    else if (ix == IDX_CH4) chan_of = 4'h4;
    else if (ix == IDX_CH5) chan_of = 4'h5;
    else if (ix == IDX_CH6) chan_of = 4'h6;
    else if (ix == IDX_CH7) chan_of = 4'h7;
    else if (ix == IDX_CH8) chan_of = 4'h8;
    else if (ix == IDX_CH9) chan_of = 4'h9;
    else chan_of = 4'ha;
  endfunction

  // Linear magnitude of each threshold code; reserved codes use the top level.
  function automatic logic [DW-1:0] thr_mag(input logic [4:0] c);
    case (c)
      5'h01:   thr_mag = 24'h020000;
      5'h02:   thr_mag = 24'h010000;
      5'h03:   thr_mag = 24'h008000;
      5'h04:   thr_mag = 24'h005f96;
      5'h05:   thr_mag = 24'h004000;
      5'h06:   thr_mag = 24'h002fe9;
      5'h07:   thr_mag = 24'h002000;
      5'h08:   thr_mag = 24'h001000;
      5'h09:   thr_mag = 24'h000c09;
      5'h0a:   thr_mag = 24'h000800;
      5'h0b:   thr_mag = 24'h000608;
      5'h0c:   thr_mag = 24'h0003fc;
      5'h0d:   thr_mag = 24'h0002fd;
      default: thr_mag = 24'h040000;
    endcase
  endfunction

  // Hold length in 4 ms ticks for each hold code.
  function automatic logic [7:0] hold_ticks(input logic [3:0] c);
    case (c)
      4'hb:    hold_ticks = 8'd12;
      4'hc:    hold_ticks = 8'd24;
      4'hd:    hold_ticks = 8'd48;
      4'he:    hold_ticks = 8'd96;
      4'hf:    hold_ticks = 8'd192;
      4'h0:    hold_ticks = 8'd1;
      default: hold_ticks = {4'h0, c};
    endcase
  endfunction

  // Merges the two low byte lanes of a write into a 16-bit value.
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  logic [DW-1:0] mag;
  logic          smp_above;
  logic [3:0]    wch;
  logic          wr_go;
  logic [15:0]   gl_old;
  logic [15:0]   gl_new;
  assign mag       = i_smp.data[DW-1] ? DW'(-i_smp.data) : i_smp.data;
  assign smp_above = mag > thr_mag(detect_threshold_level);
  assign wch       = chan_of(aw_addr);
  assign wr_go     = (wr_state == WR_HAVE);
  assign gl_old    = {7'h0, detect_threshold_level, detect_hold_time};
  assign gl_new    = merge16(gl_old, w_data, w_strb);

  // Write address and data are taken in either order; the answer follows both.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_state  <= WR_IDLE;
      aw_have   <= 1'b0;
      w_have    <= 1'b0;
      aw_addr   <= 16'h0000;
      w_data    <= 32'h00000000;
      w_strb    <= 4'h0;
      o_awready <= 1'b0;
      o_wready  <= 1'b0;
      o_bvalid  <= 1'b0;
      o_bresp   <= RESP_OK;
    end else begin
      o_awready <= 1'b0;
      o_wready  <= 1'b0;
      case (wr_state)
        WR_IDLE: begin
          if (i_awvalid && !aw_have && !o_awready) begin
            o_awready <= 1'b1;
            aw_addr   <= i_awaddr;
            aw_have   <= 1'b1;
          end
          if (i_wvalid && !w_have && !o_wready) begin
            o_wready <= 1'b1;
            w_data   <= i_wdata;
            w_strb   <= i_wstrb;
            w_have   <= 1'b1;
          end
          if (aw_have && w_have) begin
            wr_state <= WR_HAVE;
          end
        end
        WR_HAVE: begin
          o_bvalid <= 1'b1;
          o_bresp  <= (wch != 4'ha || aw_addr[15:2] == IDX_GLOBAL ||
                       aw_addr[15:2] == IDX_PAD || aw_addr[15:2] == IDX_PATH_CFG ||
                       aw_addr[15:2] == IDX_IRQ_STAT || aw_addr[15:2] == IDX_IRQ_MASK ||
                       aw_addr[15:2] == IDX_GATE || aw_addr[15:2] == IDX_ANC)
                      ? RESP_OK : RESP_ERR;
          wr_state <= WR_RESP;
        end
        WR_RESP: begin
          if (i_bready) begin
            o_bvalid <= 1'b0;
            aw_have  <= 1'b0;
            w_have   <= 1'b0;
            wr_state <= WR_IDLE;
          end
        end
        default: wr_state <= WR_IDLE;
      endcase
    end
  end

  // Control registers.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      chan_detect_enable     <= '0;
      detect_threshold_level <= THR_RST;
      detect_hold_time       <= HOLD_RST;
      path_input_type_select <= 2'h0;
      path_enable            <= 2'h0;
      pad_pulldown           <= 2'h0;
      rx_cancel_left_source  <= 3'h0;
      rx_cancel_right_source <= 3'h0;
      irq_mask               <= 1'b0;
    end else if (wr_go) begin
      if (wch != 4'ha && w_strb[1]) begin
        chan_detect_enable[wch] <= w_data[POS_ENA];
      end else if (aw_addr[15:2] == IDX_GLOBAL) begin
        {detect_threshold_level, detect_hold_time} <= gl_new[8:0];
      end else if (aw_addr[15:2] == IDX_PAD && w_strb[0]) begin
        pad_pulldown <= w_data[1:0];
      end else if (aw_addr[15:2] == IDX_PATH_CFG && w_strb[0]) begin
        path_input_type_select <= w_data[1:0];
        path_enable            <= w_data[3:2];
      end else if (aw_addr[15:2] == IDX_IRQ_MASK && w_strb[0]) begin
        irq_mask <= w_data[0];
      end else if (aw_addr[15:2] == IDX_ANC && w_strb[0]) begin
        rx_cancel_right_source <= w_data[POS_ANC_R +: 3];
        rx_cancel_left_source  <= w_data[POS_ANC_L +: 3];
      end
    end
  end

  // Read channel: one read at a time, answered two cycles after the address.
  logic [3:0] rch;
  assign rch = chan_of(i_araddr);
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h00000000;
      o_rresp   <= RESP_OK;
    end else if (o_rvalid) begin
      if (i_rready) begin
        o_rvalid <= 1'b0;
      end
    end else if (o_arready) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b1;
    end else if (i_arvalid) begin
      o_arready <= 1'b1;
      o_rresp   <= RESP_OK;
      if (rch != 4'ha) begin
        o_rdata <= {16'h0, chan_detect_enable[rch], 15'h0};
      end else if (i_araddr[15:2] == IDX_GLOBAL) begin
        o_rdata <= {23'h0, detect_threshold_level, detect_hold_time};
      end else if (i_araddr[15:2] == IDX_PAD) begin
        o_rdata <= {30'h0, pad_pulldown};
      end else if (i_araddr[15:2] == IDX_PATH_CFG) begin
        o_rdata <= {28'h0, path_enable, path_input_type_select};
      end else if (i_araddr[15:2] == IDX_IRQ_STAT) begin
        o_rdata <= {31'h0, irq_stat};
      end else if (i_araddr[15:2] == IDX_IRQ_MASK) begin
        o_rdata <= {31'h0, irq_mask};
      end else if (i_araddr[15:2] == IDX_GATE) begin
        o_rdata <= {21'h0, armed, gate_open};
      end else if (i_araddr[15:2] == IDX_ANC) begin
        o_rdata <= {25'h0, rx_cancel_right_source, 1'b0, rx_cancel_left_source};
      end else begin
        o_rdata <= 32'h00000000;
        o_rresp <= RESP_ERR;
      end
    end
  end

  // Free-running 4 ms tick for the hold timers.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tick_cnt <= 32'h00000000;
      tick     <= 1'b0;
    end else begin
      tick     <= (tick_cnt == 32'(HOLD_TICK - 1));
      tick_cnt <= (tick_cnt == 32'(HOLD_TICK - 1)) ? 32'h00000000 : tick_cnt + 32'h1;
    end
  end

  // Per-channel gate: open at once above threshold, closed after the hold.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      gate_open <= '0;
      above     <= '0;
      for (int i = 0; i < NCH; i++) begin
        hold_cnt[i] <= 8'h00;
      end
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (!chan_detect_enable[i]) begin
          gate_open[i] <= 1'b0;
          above[i]     <= 1'b0;
          hold_cnt[i]  <= 8'h00;
        end else if (i_smp.valid && i_smp.chan == 4'(i) && smp_above) begin
          gate_open[i] <= 1'b1;
          above[i]     <= 1'b1;
          hold_cnt[i]  <= 8'h00;
        end else begin
          if (i_smp.valid && i_smp.chan == 4'(i)) begin
            above[i] <= 1'b0;
          end
          if (tick && gate_open[i] && !above[i]) begin
            if (hold_cnt[i] >= hold_ticks(detect_hold_time)) begin
              gate_open[i] <= 1'b0;
              hold_cnt[i]  <= 8'h00;
            end else begin
              hold_cnt[i] <= hold_cnt[i] + 8'h01;
            end
          end
        end
      end
    end
  end

  // Sample path: enabled channels pass while their gate is open or the sample is above threshold.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_smp <= '0;
    end else begin
      o_smp.valid <= i_smp.valid;
      o_smp.chan  <= i_smp.chan;
      if (i_smp.chan < 4'(NCH) && chan_detect_enable[i_smp.chan] &&
          !gate_open[i_smp.chan] && !smp_above) begin
        o_smp.data <= '0;
      end else begin
        o_smp.data <= i_smp.data;
      end
    end
  end

  // Shared detect event and its interrupt status.
  logic stat_clr;
  assign stat_clr = wr_go && aw_addr[15:2] == IDX_IRQ_STAT && w_strb[0] && w_data[0];
  assign det_event = armed && (|above);
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      armed    <= 1'b1;
      irq_stat <= 1'b0;
      o_irq    <= 1'b0;
    end else begin
      if (det_event) begin
        armed <= 1'b0;
      end else if (!(|above)) begin
        armed <= 1'b1;
      end
      if (det_event) begin
        irq_stat <= 1'b1;
      end else if (stat_clr) begin
        irq_stat <= 1'b0;
      end
      o_irq <= (irq_stat || det_event) && irq_mask;
    end
  end

  // Microphone pins of paths 1 and 2, and the cancel source outputs.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      mic_div         <= 8'h00;
      mic_phase       <= 1'b0;
      o_mic_clk       <= 2'h0;
      o_mic_clk_oe    <= 2'h0;
      o_mic_dat_oe    <= 2'h0;
      o_mic_dat_pd    <= 2'h0;
      o_anc_left_src  <= 3'h0;
      o_anc_right_src <= 3'h0;
    end else begin
      if (mic_div == 8'(MIC_CLK_HALF - 1)) begin
        mic_div   <= 8'h00;
        mic_phase <= !mic_phase;
      end else begin
        mic_div <= mic_div + 8'h01;
      end
      o_mic_clk_oe <= path_input_type_select & path_enable;
      o_mic_clk    <= {2{mic_phase}} & path_input_type_select & path_enable;
      o_mic_dat_oe <= 2'h0;
      o_mic_dat_pd <= pad_pulldown & path_input_type_select & path_enable;
      o_anc_left_src  <= (rx_cancel_left_source > ANC_MAX) ? 3'h0 : rx_cancel_left_source;
      o_anc_right_src <= (rx_cancel_right_source > ANC_MAX) ? 3'h0 : rx_cancel_right_source;
    end
  end

  AST_UNMUTE_NOW: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_smp.valid && smp_above |=> o_smp.data == $past(i_smp.data))
    else $error("Sample above threshold was not passed.");
  AST_MUTE_BELOW: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_smp.valid && i_smp.chan < 4'(NCH) && chan_detect_enable[i_smp.chan] &&
    !gate_open[i_smp.chan] && !smp_above |=> o_smp.data == '0)
    else $error("Closed channel passed a sample.");
  AST_DISABLED_SHUT: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !chan_detect_enable[0] |=> !gate_open[0])
    else $error("Disabled channel gate stayed open.");
  AST_HOLD_RESTART: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_smp.valid && i_smp.chan == 4'h0 && smp_above && chan_detect_enable[0]
    |=> hold_cnt[0] == 8'h00 && gate_open[0])
    else $error("Hold timer did not restart.");
  AST_HOLD_EARLY: assert property (@(posedge i_clk) disable iff (!i_rstn)
    $fell(gate_open[0]) && $past(chan_detect_enable[0])
    |-> $past(hold_cnt[0]) >= hold_ticks($past(detect_hold_time)))
    else $error("Channel remuted before hold time.");
  AST_EVENT_ONCE: assert property (@(posedge i_clk) disable iff (!i_rstn)
    det_event |=> !armed ##1 !det_event)
    else $error("Detect event rearmed too early.");
  AST_REARM: assert property (@(posedge i_clk) disable iff (!i_rstn)
    $rose(armed) |-> $past(~|above))
    else $error("Rearmed while a channel is above threshold.");
  AST_IRQ_STICKY: assert property (@(posedge i_clk) disable iff (!i_rstn)
    det_event |=> irq_stat ##1 (o_irq == irq_mask || !irq_stat))
    else $error("Detect event did not reach interrupt.");
  AST_PD_OFF: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !path_enable[1] |=> !o_mic_dat_pd[1])
    else $error("Pull-down active on disabled path.");
  AST_CLK_DRIVE: assert property (@(posedge i_clk) disable iff (!i_rstn)
    path_input_type_select[0] && path_enable[0] |=> o_mic_clk_oe[0] && !o_mic_dat_oe[0])
    else $error("Microphone clock pin not driven.");
endmodule

// file: logic/sdg_pkg.sv
// Constants, types and register map of the input signal-detect gate.
// Behaviour
// - Per-channel detect enable bit 15, reset off
// - One threshold field 8:4 for all channels
// - Threshold codes 0x00..0x0D, -30.1 to -80.8 dB
// - Enabled channel outputs zero while below threshold
// - Unmute immediately when level exceeds threshold
// - Remute only after below longer than hold
// - Hold field 3:0, reset 0001, 4 ms steps
// - One OR-ed detect event, no channel indication
// - Event rearms only after all channels below
// - Paths 1 and 2 select analog or microphone
// - Microphone mode drives clock, data is input
// - Cancel sources: right 6:4, left 2:0
// - Path 2 data pull-down at bit 1
// - Pull-down off while microphone path disabled
package sdg_pkg;
  localparam int NCH = 10;
  localparam int DW  = 24;
  // Register indexes; the byte address is four times the index.
  localparam logic [13:0] IDX_CH0      = 14'h312;
  localparam logic [13:0] IDX_CH1      = 14'h316;
  localparam logic [13:0] IDX_CH2      = 14'h31a;
  localparam logic [13:0] IDX_CH3      = 14'h31e;
  localparam logic [13:0] IDX_CH4      = 14'h320;
  localparam logic [13:0] IDX_CH5      = 14'h326;
  localparam logic [13:0] IDX_CH6      = 14'h32a;
  localparam logic [13:0] IDX_CH7      = 14'h32e;
  localparam logic [13:0] IDX_CH8      = 14'h332;
  localparam logic [13:0] IDX_CH9      = 14'h336;
  localparam logic [13:0] IDX_GLOBAL   = 14'h340;
  localparam logic [13:0] IDX_PAD      = 14'h348;
  localparam logic [13:0] IDX_PATH_CFG = 14'h350;
  localparam logic [13:0] IDX_IRQ_STAT = 14'h351;
  localparam logic [13:0] IDX_IRQ_MASK = 14'h352;
  localparam logic [13:0] IDX_GATE     = 14'h353;
  localparam logic [13:0] IDX_ANC      = 14'hf01;
  localparam int POS_ENA   = 15;
  localparam int POS_THR   = 4;
  localparam int POS_HOLD  = 0;
  localparam int POS_ANC_R = 4;
  localparam int POS_ANC_L = 0;
  localparam int POS_ARMED = 10;
  localparam logic [4:0] THR_RST  = 5'h00;
  localparam logic [3:0] HOLD_RST = 4'h1;
  localparam logic [4:0] THR_MAX  = 5'h0d;
  localparam logic [2:0] ANC_MAX  = 3'h5;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  localparam int CLK_MHZ      = 250;
  localparam int HOLD_STEP_MS = 4;
  localparam int HOLD_STEP_CYC = HOLD_STEP_MS * 1000 * CLK_MHZ;
  localparam int MIC_CLK_HALF = 82;
  typedef struct packed {
    logic          valid;
    logic [3:0]    chan;
    logic [DW-1:0] data;
  } sdg_smp_t;
  typedef enum logic [2:0] {
    WR_IDLE = 3'b001,
    WR_HAVE = 3'b010,
    WR_RESP = 3'b100
  } sdg_wr_t;
endpackage

// file: verif/sdg_src_model.sv
// Upstream audio sample source that offers one sample per request.
`timescale 1ns/10ps
module sdg_src_model import sdg_pkg::*; (
  input  wire logic          i_clk,
  input  wire logic          i_rstn,
  input  wire logic          i_req,
  input  wire logic [3:0]    i_chan,
  input  wire logic [DW-1:0] i_data,
  output sdg_smp_t           o_smp
);
  // Samples arrive after gain, mute and volume; the host keeps the path on and unmuted.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_smp <= '0;
    end else if (i_req) begin
      o_smp <= {1'b1, i_chan, i_data};
    end else begin
      o_smp <= {1'b0, ~o_smp.chan, ~o_smp.data};
    end
  end
endmodule

// file: verif/tb_input_signal_detect_gate.sv
// Self-checking bench for the input signal-detect gate.
`timescale 1ns/10ps
module tb_input_signal_detect_gate import sdg_pkg::*; ;
  logic          clk = 1'b0, rstn = 1'b0, req = 1'b0;
  logic          awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [15:0]   awaddr = '0, araddr = '0;
  logic [31:0]   wdata = '0, rdata;
  logic [3:0]    wstrb = '0, chan = '0;
  logic [DW-1:0] sdata = '0;
  sdg_smp_t      smp_in, smp_out;
  logic          awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]    bresp, rresp, mclk, mclk_oe, mdat_oe, mdat_pd;
  logic [2:0]    anc_l, anc_r;
  int            error_cnt = 0, n_tests = 0;

  always #2 clk = ~clk;

  sdg_src_model src_u (.i_clk(clk), .i_rstn(rstn), .i_req(req), .i_chan(chan), .i_data(sdata),
                       .o_smp(smp_in));
  sdg_gate #(.HOLD_TICK(20)) dut_u (
    .i_clk(clk), .i_rstn(rstn), .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
    .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(wstrb), .o_bvalid(bvalid),
    .i_bready(bready), .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready),
    .i_araddr(araddr), .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp),
    .i_smp(smp_in), .o_smp(smp_out), .o_irq(irq), .o_mic_clk(mclk), .o_mic_clk_oe(mclk_oe),
    .o_mic_dat_oe(mdat_oe), .o_mic_dat_pd(mdat_pd), .o_anc_left_src(anc_l),
    .o_anc_right_src(anc_r));

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic hang(input string what);
    error_cnt++;
    $display("CHECK FAILED %s expected answer seen timeout", what);
    report_and_stop();
  endtask

  task automatic axi_wr(input logic [13:0] idx, input logic [31:0] d, input logic [1:0] er);
    int n;
    bit aw, w;
    aw = 1;
    w = 1;
    n = 0;
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr <= {idx, 2'b00};
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'h3;
    bready <= 1'b1;
    while ((aw || w || bvalid !== 1'b1) && n < 50) begin
      @(posedge clk);
      n++;
      if (aw && awready === 1'b1) begin
        awvalid <= 1'b0;
        aw = 0;
      end
      if (w && wready === 1'b1) begin
        wvalid <= 1'b0;
        w = 0;
      end
    end
    if (n >= 50) hang("write");
    bready <= 1'b0;
    cmp("write resp", {30'h0, er}, {30'h0, bresp});
  endtask

  task automatic reg_chk(input logic [13:0] idx, input logic [31:0] ed, input logic [1:0] er,
                         input string what);
    int n;
    bit ar;
    ar = 1;
    n = 0;
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= {idx, 2'b00};
    rready <= 1'b1;
    while ((ar || rvalid !== 1'b1) && n < 50) begin
      @(posedge clk);
      n++;
      if (ar && arready === 1'b1) begin
        arvalid <= 1'b0;
        ar = 0;
      end
    end
    if (n >= 50) hang("read");
    rready <= 1'b0;
    cmp(what, ed, rdata);
    cmp("read resp", {30'h0, er}, {30'h0, rresp});
  endtask

  task automatic send(input logic [3:0] c, input logic [DW-1:0] d, input logic [DW-1:0] exp);
    @(posedge clk);
    req <= 1'b1;
    chan <= c;
    sdata <= d;
    @(posedge clk);
    req <= 1'b0;
    @(posedge clk);
    #1;
    cmp("sample valid", 32'h1, {31'h0, smp_out.valid});
    cmp("sample chan", {28'h0, c}, {28'h0, smp_out.chan});
    cmp("sample data", {8'h0, exp}, {8'h0, smp_out.data});
  endtask

  task automatic irq_chk(input logic e);
    repeat (3) @(posedge clk);
    #1;
    cmp("irq", {31'h0, e}, {31'h0, irq});
  endtask

  task automatic pins_chk(input logic [1:0] oe, input logic [1:0] pd);
    repeat (3) @(posedge clk);
    #1;
    cmp("clock oe", {30'h0, oe}, {30'h0, mclk_oe});
    cmp("data oe", 32'h0, {30'h0, mdat_oe});
    cmp("pull-down", {30'h0, pd}, {30'h0, mdat_pd});
  endtask

  task automatic t_reset_values();
    reg_chk(IDX_CH0, 32'h0, RESP_OK, "chan ctrl");
    reg_chk(IDX_GLOBAL, 32'h1, RESP_OK, "globals");
    reg_chk(IDX_PAD, 32'h0, RESP_OK, "pad");
    reg_chk(IDX_ANC, 32'h0, RESP_OK, "cancel src");
    reg_chk(IDX_GATE, 32'h400, RESP_OK, "gate status");
    reg_chk(14'h100, 32'h0, RESP_ERR, "unmapped");
    axi_wr(14'h100, 32'hffff, RESP_ERR);
  endtask

  task automatic t_gate_hold();
    axi_wr(IDX_IRQ_MASK, 32'h1, RESP_OK);
    axi_wr(IDX_GLOBAL, 32'h3, RESP_OK);
    axi_wr(IDX_CH0, 32'h8000, RESP_OK);
    axi_wr(IDX_CH3, 32'h8000, RESP_OK);
    reg_chk(IDX_CH0, 32'h8000, RESP_OK, "chan ctrl");
    send(4'd0, 24'h000100, 24'h0);
    send(4'd5, 24'h000100, 24'h000100);
    irq_chk(1'b0);
    send(4'd0, 24'h050000, 24'h050000);
    send(4'd0, 24'h000100, 24'h000100);
    repeat (38) @(posedge clk);
    send(4'd0, 24'h050000, 24'h050000);
    send(4'd0, 24'h000100, 24'h000100);
    repeat (55) @(posedge clk);
    send(4'd0, 24'h000100, 24'h000100);
    repeat (120) @(posedge clk);
    send(4'd0, 24'h000100, 24'h0);
  endtask

  task automatic t_event();
    axi_wr(IDX_IRQ_STAT, 32'h1, RESP_OK);
    irq_chk(1'b0);
    send(4'd0, 24'h050000, 24'h050000);
    irq_chk(1'b1);
    axi_wr(IDX_IRQ_STAT, 32'h1, RESP_OK);
    send(4'd3, 24'hfb0000, 24'hfb0000);
    irq_chk(1'b0);
    send(4'd0, 24'h000100, 24'h000100);
    send(4'd3, 24'h000100, 24'h000100);
    send(4'd3, 24'h050000, 24'h050000);
    irq_chk(1'b1);
    reg_chk(IDX_IRQ_STAT, 32'h1, RESP_OK, "irq status");
    axi_wr(IDX_IRQ_MASK, 32'h0, RESP_OK);
    irq_chk(1'b0);
  endtask

  task automatic t_threshold();
    axi_wr(IDX_GLOBAL, 32'hd3, RESP_OK);
    axi_wr(IDX_CH9, 32'h8000, RESP_OK);
    axi_wr(IDX_CH4, 32'h8000, RESP_OK);
    reg_chk(IDX_GLOBAL, 32'hd3, RESP_OK, "globals");
    send(4'd9, 24'h0002fd, 24'h0);
    send(4'd9, 24'h000300, 24'h000300);
    send(4'd4, 24'h000200, 24'h0);
    send(4'd4, 24'hfffd00, 24'hfffd00);
    axi_wr(IDX_GLOBAL, 32'hdb, RESP_OK);
    send(4'd9, 24'h000300, 24'h000300);
    send(4'd9, 24'h000100, 24'h000100);
    repeat (230) @(posedge clk);
    send(4'd9, 24'h000100, 24'h000100);
    repeat (30) @(posedge clk);
    send(4'd9, 24'h000100, 24'h0);
  endtask

  task automatic t_mic_pins();
    int t;
    logic last;
    t = 0;
    axi_wr(IDX_PATH_CFG, 32'h5, RESP_OK);
    axi_wr(IDX_PAD, 32'h3, RESP_OK);
    pins_chk(2'b01, 2'b01);
    cmp("clock 2 idle", 32'h0, {31'h0, mclk[1]});
    axi_wr(IDX_PATH_CFG, 32'hf, RESP_OK);
    pins_chk(2'b11, 2'b11);
    axi_wr(IDX_PAD, 32'h2, RESP_OK);
    pins_chk(2'b11, 2'b10);
    last = mclk[0];
    for (int i = 0; i < 200; i++) begin
      @(posedge clk);
      #1;
      if (mclk[0] !== last) t++;
      last = mclk[0];
    end
    cmp("clock toggles", 32'h1, {31'h0, t >= 2});
  endtask

  task automatic t_cancel_src();
    for (int i = 0; i < 6; i++) begin
      axi_wr(IDX_ANC, {25'h0, i[2:0], 1'b0, 3'(5 - i)}, RESP_OK);
      repeat (2) @(posedge clk);
      #1;
      cmp("right src", i, {29'h0, anc_r});
      cmp("left src", 5 - i, {29'h0, anc_l});
    end
    axi_wr(IDX_ANC, 32'h76, RESP_OK);
    repeat (2) @(posedge clk);
    #1;
    cmp("reserved src", 32'h0, {26'h0, anc_r, anc_l});
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    t_reset_values();
    t_gate_hold();
    t_event();
    t_threshold();
    t_mic_pins();
    t_cancel_src();
    report_and_stop();
  end

  initial begin
    repeat (100000) @(posedge clk);
    hang("run");
  end
endmodule
